// >>> common/bcfp_pkg.sv
package bcfp_pkg;
	// queue geometry
	localparam int DEPTH = 64;
	localparam int WIDTH = 36;
	localparam int AW = 6;
	localparam int CW = 7;
	localparam int BYTE_W = 9;
	localparam int DATA_W = 8;
	localparam int HALF_W = 18;
	localparam int NBYTES = 4;
	localparam logic [CW-1:0] DEPTH_CNT = 7'h40;
	// near flag offsets chosen by the two offset select pins at reset
	localparam logic [CW-1:0] OFFSET_P0 = 7'h10;
	localparam logic [CW-1:0] OFFSET_P1 = 7'h0c;
	localparam logic [CW-1:0] OFFSET_P2 = 7'h08;
	localparam logic [CW-1:0] OFFSET_P3 = 7'h04;
	// flag slots inside a queue
	localparam int NFLAG = 4;
	localparam int FL_EMPTY = 0;
	localparam int FL_FULL = 1;
	localparam int FL_NEMPTY = 2;
	localparam int FL_NFULL = 3;
	// port b size select codes
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h2;
	localparam logic [1:0] SIZE_MAIL = 2'h3;
	// byte order swap modes
	localparam logic [1:0] SWAP_NONE = 2'h0;
	localparam logic [1:0] SWAP_FULL = 2'h1;
	localparam logic [1:0] SWAP_HALF = 2'h2;
	localparam logic [1:0] SWAP_BYTE = 2'h3;
	// register map, byte addresses
	localparam int ADR_W = 4;
	localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam int CTRL_SWAP_LSB = 0;
	localparam int CTRL_ODD_BIT = 2;
	localparam int CTRL_GEN_A_BIT = 3;
	localparam int CTRL_GEN_B_BIT = 4;
	localparam int ST_A2B_LSB = 0;
	localparam int ST_B2A_LSB = 8;
	localparam int ST_AB_MAIL_BIT = 16;
	localparam int ST_BA_MAIL_BIT = 17;
	localparam int ST_PERR_A_BIT = 18;
	localparam int ST_PERR_B_BIT = 19;
	localparam int ST_OFS_LSB = 20;

	function automatic logic [WIDTH-1:0] byte_swap(input logic [WIDTH-1:0] d, input logic [1:0] m);
		logic [WIDTH-1:0] r;
		case (m)
			SWAP_FULL: r = {d[0 +: BYTE_W], d[BYTE_W +: BYTE_W], d[2*BYTE_W +: BYTE_W], d[3*BYTE_W +: BYTE_W]};
			SWAP_HALF: r = {d[0 +: HALF_W], d[HALF_W +: HALF_W]};
			SWAP_BYTE: r = {d[2*BYTE_W +: BYTE_W], d[3*BYTE_W +: BYTE_W], d[0 +: BYTE_W], d[BYTE_W +: BYTE_W]};
			default: r = d;
		endcase
		return r;
	endfunction

	// every byte carries its parity in its top bit
	function automatic logic par_ok(input logic [WIDTH-1:0] d, input logic odd);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < NBYTES; i++) ok = ok & ((^d[i*BYTE_W +: BYTE_W]) == odd);
		return ok;
	endfunction

	function automatic logic [WIDTH-1:0] par_gen(input logic [WIDTH-1:0] d, input logic odd);
		logic [WIDTH-1:0] r;
		r = d;
		for (int i = 0; i < NBYTES; i++) r[i*BYTE_W+DATA_W] = (^d[i*BYTE_W +: DATA_W]) ^ odd;
		return r;
	endfunction

	function automatic logic [1:0] last_step(input logic [1:0] size);
		case (size)
			SIZE_WORD: return 2'h1;
			SIZE_BYTE: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction
endpackage

// >>> rtl/bcfp_queue.sv
`timescale 1ns/1ns
`default_nettype none
module bcfp_queue import bcfp_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic pop_i,
	input wire logic [CW-1:0] offset_i,
	output logic [WIDTH-1:0] head_o,
	output logic [CW-1:0] count_o,
	output logic empty_n_o,
	output logic full_n_o,
	output logic near_empty_n_o,
	output logic near_full_n_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [NFLAG-1:0] ok_now, ok_next, s1_r, s1_nxt, s2_r, s2_nxt;

	// caller only pushes when not full and pops when not empty
	always_comb begin
		wptr_nxt = wptr_r + AW'(push_i);
		rptr_nxt = rptr_r + AW'(pop_i);
		cnt_nxt = cnt_r + CW'(push_i) - CW'(pop_i);
		ok_now[FL_EMPTY] = cnt_r != '0;
		ok_now[FL_FULL] = cnt_r != DEPTH_CNT;
		ok_now[FL_NEMPTY] = cnt_r > offset_i;
		ok_now[FL_NFULL] = (DEPTH_CNT - cnt_r) > offset_i;
		ok_next[FL_EMPTY] = cnt_nxt != '0;
		ok_next[FL_FULL] = cnt_nxt != DEPTH_CNT;
		ok_next[FL_NEMPTY] = cnt_nxt > offset_i;
		ok_next[FL_NFULL] = (DEPTH_CNT - cnt_nxt) > offset_i;
	end

	// flags drop at once but take two stages to rise again
	for (genvar i = 0; i < NFLAG; i++) begin : g_flag
		assign s1_nxt[i] = ok_now[i] & ok_next[i];
		assign s2_nxt[i] = s1_r[i] & ok_next[i];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_i) begin
		if (push_i) begin
			mem[wptr_r] <= wdata_i;
		end
	end

	assign head_o = mem[rptr_r];
	assign count_o = cnt_r;
	assign empty_n_o = s2_r[FL_EMPTY];
	assign full_n_o = s2_r[FL_FULL];
	assign near_empty_n_o = s2_r[FL_NEMPTY];
	assign near_full_n_o = s2_r[FL_NFULL];
endmodule
`default_nettype wire

// >>> rtl/bcfp_top.sv
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bcfp_top import bcfp_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic offset_select_lo_i,
	input wire logic offset_select_hi_i,
	input wire logic port_a_select_n_i,
	input wire logic port_a_enable_i,
	input wire logic port_a_write_i,
	input wire logic port_a_mailbox_i,
	input wire logic [WIDTH-1:0] port_a_data_bus_i,
	output logic [WIDTH-1:0] port_a_data_bus_o,
	output logic port_a_data_bus_oe_o,
	output logic port_a_empty_n_o,
	output logic port_a_full_n_o,
	output logic port_a_near_empty_n_o,
	output logic port_a_near_full_n_o,
	output logic port_a_parity_err_n_o,
	input wire logic port_b_select_n_i,
	input wire logic port_b_enable_i,
	input wire logic port_b_write_i,
	input wire logic [1:0] port_b_size_i,
	input wire logic endian_select_n_i,
	input wire logic [WIDTH-1:0] port_b_data_bus_i,
	output logic [WIDTH-1:0] port_b_data_bus_o,
	output logic port_b_data_bus_oe_o,
	output logic port_b_empty_n_o,
	output logic port_b_full_n_o,
	output logic port_b_near_empty_n_o,
	output logic port_b_near_full_n_o,
	output logic port_b_parity_err_n_o,
	output logic a_to_b_mail_flag_n_o,
	output logic b_to_a_mail_flag_n_o
);
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt, status;
	logic wb_req;
	logic [1:0] ofs_sel_r, ofs_sel_nxt;
	logic [CW-1:0] offset;
	logic odd, gen_a, gen_b;
	logic [1:0] swap_mode;
	logic a_acc, a_wr, a_rd, a_push, a_pop, a_mail_wr, a_mail_rd, a_force;
	logic b_acc, b_wr, b_rd, b_mail, b_push, b_pop, b_mail_wr, b_mail_rd, b_force;
	logic b_piece_wr, b_piece_rd, b_last_w, b_last_r;
	logic [1:0] b_last, wstep_r, wstep_nxt, rstep_r, rstep_nxt, wpos, rpos;
	logic [WIDTH-1:0] asm_r, asm_nxt, word_in, head_sw, piece_out;
	logic [WIDTH-1:0] ab_head, ba_head;
	logic [CW-1:0] a2b_cnt, b2a_cnt;
	logic [WIDTH-1:0] ab_mail_r, ab_mail_nxt, ba_mail_r, ba_mail_nxt;
	logic ab_flag_n_r, ab_flag_n_nxt, ba_flag_n_r, ba_flag_n_nxt;
	logic [WIDTH-1:0] a_dout_r, a_dout_nxt, b_dout_r, b_dout_nxt;
	logic a_oe_r, a_oe_nxt, b_oe_r, b_oe_nxt;
	logic a_perr_n_r, a_perr_n_nxt, b_perr_n_r, b_perr_n_nxt;

	assign odd = ctrl_r[CTRL_ODD_BIT];
	assign gen_a = ctrl_r[CTRL_GEN_A_BIT];
	assign gen_b = ctrl_r[CTRL_GEN_B_BIT];
	assign swap_mode = ctrl_r[CTRL_SWAP_LSB +: 2];

	// wishbone slave, one wait state, unmapped reads return zero
	always_comb begin
		wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
		ack_nxt = wb_req;
		ctrl_nxt = ctrl_r;
		status = '0;
		status[ST_A2B_LSB +: CW] = a2b_cnt;
		status[ST_B2A_LSB +: CW] = b2a_cnt;
		status[ST_AB_MAIL_BIT] = ~ab_flag_n_r;
		status[ST_BA_MAIL_BIT] = ~ba_flag_n_r;
		status[ST_PERR_A_BIT] = ~a_perr_n_r;
		status[ST_PERR_B_BIT] = ~b_perr_n_r;
		status[ST_OFS_LSB +: 2] = ofs_sel_r;
		dat_nxt = dat_r;
		if (wb_req) begin
			dat_nxt = '0;
			if (wb_adr_i == REG_CTRL) begin
				dat_nxt[CTRL_W-1:0] = ctrl_r;
				if (wb_we_i && wb_sel_i[0]) begin
					ctrl_nxt = wb_dat_i[CTRL_W-1:0];
				end
			end else if (wb_adr_i == REG_STATUS) begin
				dat_nxt = status;
			end
		end
	end

	// offset select is sampled throughout reset, so the value at release sticks
	always_comb begin
		ofs_sel_nxt = rst_i ? {offset_select_hi_i, offset_select_lo_i} : ofs_sel_r;
		case (ofs_sel_r)
			2'h1: offset = OFFSET_P1;
			2'h2: offset = OFFSET_P2;
			2'h3: offset = OFFSET_P3;
			default: offset = OFFSET_P0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		ofs_sel_r <= ofs_sel_nxt;
		if (rst_i) begin
			ctrl_r <= CTRL_RST;
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// access decode; ports share clk_i, so both clocks are coincident
	always_comb begin
		a_acc = ~port_a_select_n_i & port_a_enable_i;
		a_wr = a_acc & port_a_write_i;
		a_rd = a_acc & ~port_a_write_i;
		a_mail_wr = a_wr & port_a_mailbox_i & ab_flag_n_r;
		a_push = a_wr & ~port_a_mailbox_i & port_a_full_n_o;
		a_mail_rd = a_rd & port_a_mailbox_i;
		a_pop = a_rd & ~port_a_mailbox_i & port_a_empty_n_o;
		b_acc = ~port_b_select_n_i & port_b_enable_i;
		b_wr = b_acc & port_b_write_i;
		b_rd = b_acc & ~port_b_write_i;
		b_mail = port_b_size_i == SIZE_MAIL;
		b_mail_wr = b_wr & b_mail & ba_flag_n_r;
		b_mail_rd = b_rd & b_mail;
		b_last = last_step(port_b_size_i);
		b_last_w = wstep_r == b_last;
		b_last_r = rstep_r == b_last;
		b_piece_wr = b_wr & ~b_mail & port_b_full_n_o;
		b_piece_rd = b_rd & ~b_mail & port_b_empty_n_o;
		b_push = b_piece_wr & b_last_w;
		b_pop = b_piece_rd & b_last_r;
	end

	// port b write sizing: pieces gather into one word before the push
	always_comb begin
		wpos = endian_select_n_i ? wstep_r : b_last - wstep_r;
		word_in = asm_r;
		case (port_b_size_i)
			SIZE_WORD: begin
				word_in[wpos[0]*HALF_W +: HALF_W] = endian_select_n_i ?
					port_b_data_bus_i[0 +: HALF_W] : port_b_data_bus_i[HALF_W +: HALF_W];
			end
			SIZE_BYTE: begin
				word_in[wpos*BYTE_W +: BYTE_W] = endian_select_n_i ?
					port_b_data_bus_i[0 +: BYTE_W] : port_b_data_bus_i[3*BYTE_W +: BYTE_W];
			end
			default: begin
				word_in = port_b_data_bus_i;
			end
		endcase
		asm_nxt = asm_r;
		wstep_nxt = wstep_r;
		if (b_piece_wr) begin
			asm_nxt = word_in;
			wstep_nxt = b_last_w ? 2'h0 : wstep_r + 2'h1;
		end
	end

	// port b read sizing: the head word leaves piece by piece, popped with the last
	always_comb begin
		head_sw = byte_swap(ab_head, swap_mode);
		rpos = endian_select_n_i ? rstep_r : b_last - rstep_r;
		piece_out = '0;
		case (port_b_size_i)
			SIZE_WORD: begin
				if (endian_select_n_i) begin
					piece_out[0 +: HALF_W] = head_sw[rpos[0]*HALF_W +: HALF_W];
				end else begin
					piece_out[HALF_W +: HALF_W] = head_sw[rpos[0]*HALF_W +: HALF_W];
				end
			end
			SIZE_BYTE: begin
				if (endian_select_n_i) begin
					piece_out[0 +: BYTE_W] = head_sw[rpos*BYTE_W +: BYTE_W];
				end else begin
					piece_out[3*BYTE_W +: BYTE_W] = head_sw[rpos*BYTE_W +: BYTE_W];
				end
			end
			default: begin
				piece_out = head_sw;
			end
		endcase
		rstep_nxt = rstep_r;
		if (b_piece_rd) begin
			rstep_nxt = b_last_r ? 2'h0 : rstep_r + 2'h1;
		end
	end

	// mailboxes; a new write beats a same-cycle read of the flag
	always_comb begin
		ab_mail_nxt = a_mail_wr ? port_a_data_bus_i : ab_mail_r;
		ba_mail_nxt = b_mail_wr ? port_b_data_bus_i : ba_mail_r;
		ab_flag_n_nxt = ab_flag_n_r;
		if (b_mail_rd) begin
			ab_flag_n_nxt = 1'b1;
		end
		if (a_mail_wr) begin
			ab_flag_n_nxt = 1'b0;
		end
		ba_flag_n_nxt = ba_flag_n_r;
		if (a_mail_rd) begin
			ba_flag_n_nxt = 1'b1;
		end
		if (b_mail_wr) begin
			ba_flag_n_nxt = 1'b0;
		end
	end

	// output registers and parity; reads with an empty queue hold the old word
	always_comb begin
		a_dout_nxt = a_dout_r;
		if (a_mail_rd || a_pop) begin
			a_dout_nxt = a_mail_rd ? ba_mail_r : ba_head;
			if (gen_a) begin
				a_dout_nxt = par_gen(a_dout_nxt, odd);
			end
		end
		b_dout_nxt = b_dout_r;
		if (b_mail_rd || b_piece_rd) begin
			b_dout_nxt = b_mail_rd ? ab_mail_r : piece_out;
			if (gen_b) begin
				b_dout_nxt = par_gen(b_dout_nxt, odd);
			end
		end
		a_oe_nxt = ~port_a_select_n_i & ~port_a_write_i;
		b_oe_nxt = ~port_b_select_n_i & ~port_b_write_i;
		// parity tree is shared with mailbox generation, so the check is blanked then
		a_force = a_rd & port_a_mailbox_i & gen_a;
		b_force = b_rd & b_mail & gen_b;
		a_perr_n_nxt = a_force | par_ok(port_a_data_bus_i, odd);
		b_perr_n_nxt = b_force | par_ok(port_b_data_bus_i, odd);
	end

	always_ff @(posedge clk_i) begin
		asm_r <= asm_nxt;
		ab_mail_r <= ab_mail_nxt;
		ba_mail_r <= ba_mail_nxt;
		if (rst_i) begin
			wstep_r <= '0;
			rstep_r <= '0;
			ab_flag_n_r <= 1'b1;
			ba_flag_n_r <= 1'b1;
			a_dout_r <= '0;
			b_dout_r <= '0;
			a_oe_r <= 1'b0;
			b_oe_r <= 1'b0;
			a_perr_n_r <= 1'b1;
			b_perr_n_r <= 1'b1;
		end else begin
			wstep_r <= wstep_nxt;
			rstep_r <= rstep_nxt;
			ab_flag_n_r <= ab_flag_n_nxt;
			ba_flag_n_r <= ba_flag_n_nxt;
			a_dout_r <= a_dout_nxt;
			b_dout_r <= b_dout_nxt;
			a_oe_r <= a_oe_nxt;
			b_oe_r <= b_oe_nxt;
			a_perr_n_r <= a_perr_n_nxt;
			b_perr_n_r <= b_perr_n_nxt;
		end
	end

	// one queue per direction, flags all registered on clk_i
	bcfp_queue u_a_to_b_queue (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(a_push),
		.wdata_i(port_a_data_bus_i),
		.pop_i(b_pop),
		.offset_i(offset),
		.head_o(ab_head),
		.count_o(a2b_cnt),
		.empty_n_o(port_b_empty_n_o),
		.full_n_o(port_a_full_n_o),
		.near_empty_n_o(port_b_near_empty_n_o),
		.near_full_n_o(port_a_near_full_n_o)
	);

	bcfp_queue u_b_to_a_queue (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(b_push),
		.wdata_i(byte_swap(word_in, swap_mode)),
		.pop_i(a_pop),
		.offset_i(offset),
		.head_o(ba_head),
		.count_o(b2a_cnt),
		.empty_n_o(port_a_empty_n_o),
		.full_n_o(port_b_full_n_o),
		.near_empty_n_o(port_a_near_empty_n_o),
		.near_full_n_o(port_b_near_full_n_o)
	);

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign port_a_data_bus_o = a_dout_r;
	assign port_a_data_bus_oe_o = a_oe_r;
	assign port_a_parity_err_n_o = a_perr_n_r;
	assign port_b_data_bus_o = b_dout_r;
	assign port_b_data_bus_oe_o = b_oe_r;
	assign port_b_parity_err_n_o = b_perr_n_r;
	assign a_to_b_mail_flag_n_o = ab_flag_n_r;
	assign b_to_a_mail_flag_n_o = ba_flag_n_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_oe_a;
		port_a_select_n_i |=> !port_a_data_bus_oe_o;
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("port a drives while deselected");
	property p_ab_hold;
		!ab_flag_n_r && !b_mail_rd |=> ab_mail_r == $past(ab_mail_r) && !a_to_b_mail_flag_n_o;
	endproperty
	a_ab_hold: assert property (p_ab_hold) else $error("full mailbox overwritten");
	property p_ab_store;
		a_mail_wr |=> !a_to_b_mail_flag_n_o && ab_mail_r == $past(port_a_data_bus_i);
	endproperty
	a_ab_store: assert property (p_ab_store) else $error("mailbox write lost");
	property p_empty_b;
		a2b_cnt == '0 |-> !port_b_empty_n_o;
	endproperty
	a_empty_b: assert property (p_empty_b) else $error("empty flag high on empty queue");
	property p_rise_a;
		$rose(port_a_empty_n_o) |-> $past(b2a_cnt, 2) != '0;
	endproperty
	a_rise_a: assert property (p_rise_a) else $error("empty flag rose too early");
	property p_full_a;
		a2b_cnt == DEPTH_CNT |-> !port_a_full_n_o;
	endproperty
	a_full_a: assert property (p_full_a) else $error("full flag high on full queue");
	property p_ne_a;
		b2a_cnt <= offset |-> !port_a_near_empty_n_o;
	endproperty
	a_ne_a: assert property (p_ne_a) else $error("port a near-empty wrong");
	property p_ne_b;
		a2b_cnt <= offset |-> !port_b_near_empty_n_o;
	endproperty
	a_ne_b: assert property (p_ne_b) else $error("port b near-empty wrong");
	property p_nf_a;
		(DEPTH_CNT - a2b_cnt) <= offset |-> !port_a_near_full_n_o;
	endproperty
	a_nf_a: assert property (p_nf_a) else $error("port a near-full wrong");
	property p_nf_b;
		(DEPTH_CNT - b2a_cnt) <= offset |-> !port_b_near_full_n_o;
	endproperty
	a_nf_b: assert property (p_nf_b) else $error("port b near-full wrong");
	property p_same_edge;
		a_push && b_pop |=> a2b_cnt == $past(a2b_cnt);
	endproperty
	a_same_edge: assert property (p_same_edge) else $error("same-edge push and pop lost");
	property p_gen_a;
		a_pop && gen_a |=> par_ok(port_a_data_bus_o, $past(odd));
	endproperty
	a_gen_a: assert property (p_gen_a) else $error("port a parity not generated");
	property p_chk_a;
		!par_ok(port_a_data_bus_i, odd) && !a_force |=> !port_a_parity_err_n_o;
	endproperty
	a_chk_a: assert property (p_chk_a) else $error("port a parity error missed");
endmodule
`default_nettype wire

// >>> testbench/bcfp_port_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side master of one port, changes its pins just after clock edges
module bcfp_port_model import bcfp_pkg::*; (
	input wire logic clk_i,
	output logic sel_n_o,
	output logic en_o,
	output logic wr_o,
	output logic mb_o,
	output logic [WIDTH-1:0] data_o
);
	// quiet port at time zero
	initial begin
		sel_n_o = 1'b1;
		en_o = 1'b0;
		wr_o = 1'b0;
		mb_o = 1'b0;
		data_o = '0;
	end
	// one transfer per edge; calls may follow back to back
	task automatic xfer(input logic w, input logic m, input logic [WIDTH-1:0] d);
		sel_n_o <= 1'b0;
		en_o <= 1'b1;
		wr_o <= w;
		mb_o <= m;
		data_o <= d;
		@(posedge clk_i);
	endtask
	// released bus shows the inverse, so a stale word never passes
	task automatic idle();
		sel_n_o <= 1'b1;
		en_o <= 1'b0;
		data_o <= ~data_o;
	endtask
endmodule
`default_nettype wire

// >>> testbench/bidir_clocked_fifo_pair_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bidir_clocked_fifo_pair_tb import bcfp_pkg::*;;
	localparam int OFS = OFFSET_P1;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0] sel = 4'hf;
	logic [31:0] wd = '0, rd, q;
	logic [1:0] fs = 2'h1;
	logic a_sn, a_en, a_wr, a_mb, a_oe, a_ef, a_ff, a_ae, a_af, a_pe;
	logic b_sn, b_en, b_wr, b_oe, b_ef, b_ff, b_ae, b_af, b_pe, mab, mba;
	logic b_be = 1'b0;
	logic [1:0] b_sz = SIZE_LONG;
	logic [WIDTH-1:0] a_dr, a_o, a_w, b_dr, b_o, b_w, v;
	int err_total = 0;
	int comparisons = 0;

	always #5 clk = ~clk;
	// device wins the two-way bus while its enable is up
	assign a_w = a_oe ? a_o : a_dr;
	assign b_w = b_oe ? b_o : b_dr;

	bcfp_top i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.offset_select_lo_i(fs[0]), .offset_select_hi_i(fs[1]),
		.port_a_select_n_i(a_sn), .port_a_enable_i(a_en), .port_a_write_i(a_wr),
		.port_a_mailbox_i(a_mb), .port_a_data_bus_i(a_w), .port_a_data_bus_o(a_o),
		.port_a_data_bus_oe_o(a_oe), .port_a_empty_n_o(a_ef), .port_a_full_n_o(a_ff),
		.port_a_near_empty_n_o(a_ae), .port_a_near_full_n_o(a_af), .port_a_parity_err_n_o(a_pe),
		.port_b_select_n_i(b_sn), .port_b_enable_i(b_en), .port_b_write_i(b_wr),
		.port_b_size_i(b_sz), .endian_select_n_i(b_be), .port_b_data_bus_i(b_w),
		.port_b_data_bus_o(b_o), .port_b_data_bus_oe_o(b_oe), .port_b_empty_n_o(b_ef),
		.port_b_full_n_o(b_ff), .port_b_near_empty_n_o(b_ae), .port_b_near_full_n_o(b_af),
		.port_b_parity_err_n_o(b_pe), .a_to_b_mail_flag_n_o(mab), .b_to_a_mail_flag_n_o(mba));
	bcfp_port_model i_pa (.clk_i(clk), .sel_n_o(a_sn), .en_o(a_en), .wr_o(a_wr), .mb_o(a_mb),
		.data_o(a_dr));
	bcfp_port_model i_pb (.clk_i(clk), .sel_n_o(b_sn), .en_o(b_en), .wr_o(b_wr), .mb_o(),
		.data_o(b_dr));

	task automatic chk(input logic [WIDTH-1:0] g, input logic [WIDTH-1:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// classic cycle: request held until ack is sampled at an edge
	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	// the idle edge keeps a pin from being driven twice in one step
	task automatic a_put(input logic m, input logic [WIDTH-1:0] d);
		i_pa.xfer(1'b1, m, d);
		i_pa.idle();
		@(posedge clk);
		chk(a_oe, 1'b0);
	endtask
	task automatic b_put(input logic [WIDTH-1:0] d);
		i_pb.xfer(1'b1, 1'b0, d);
		i_pb.idle();
		@(posedge clk);
		chk(b_oe, 1'b0);
	endtask
	task automatic a_rd(input logic m);
		i_pa.xfer(1'b0, m, '0);
		i_pa.idle();
		@(posedge clk);
		chk(a_oe, 1'b1);
		v = a_o;
	endtask
	task automatic b_rd();
		i_pb.xfer(1'b0, 1'b0, '0);
		i_pb.idle();
		@(posedge clk);
		chk(b_oe, 1'b1);
		v = b_o;
	endtask
	function automatic logic [WIDTH-1:0] swp(input logic [WIDTH-1:0] d, input logic [1:0] s);
		case (s)
			SWAP_FULL: return {d[8:0], d[17:9], d[26:18], d[35:27]};
			SWAP_HALF: return {d[17:0], d[35:18]};
			SWAP_BYTE: return {d[26:18], d[35:27], d[8:0], d[17:9]};
			default: return d;
		endcase
	endfunction

	task automatic t_reset();
		fs <= 2'h0;
		@(posedge clk);
		chk(b_ef, 1'b0);
		chk(a_ef, 1'b0);
		chk(a_ff, 1'b0);
		chk(mab, 1'b1);
		chk(mba, 1'b1);
		repeat (3) @(posedge clk);
		chk(a_ff, 1'b1);
		chk(b_ff, 1'b1);
		chk(a_ae, 1'b0);
		wb(1'b0, REG_STATUS, '0);
		chk(q[ST_OFS_LSB +: 2], 2'h1);
		wb(1'b0, 4'hc, '0);
		chk(q, '0);
	endtask
	task automatic t_empty();
		i_pa.xfer(1'b1, 1'b0, 36'h123456789);
		i_pa.idle();
		@(posedge clk);
		chk(b_ef, 1'b0);
		repeat (2) @(posedge clk);
		chk(b_ef, 1'b1);
		b_rd();
		chk(v, 36'h123456789);
	endtask
	// flag thresholds either side of the offset, then one write too many
	task automatic t_fill();
		for (int i = 1; i <= DEPTH + 1; i++) begin
			a_put(1'b0, 36'(i));
			b_put(36'(i));
			if (i inside {OFS, OFS + 1, DEPTH - OFS - 1, DEPTH - OFS, DEPTH, DEPTH + 1}) begin
				repeat (3) @(posedge clk);
				chk(b_ae, i > OFS);
				chk(a_ae, i > OFS);
				chk(a_af, DEPTH - i > OFS);
				chk(b_af, DEPTH - i > OFS);
				chk(a_ff, i < DEPTH);
				chk(b_ff, i < DEPTH);
			end
		end
		wb(1'b0, REG_STATUS, '0);
		chk(q[ST_A2B_LSB +: CW], DEPTH_CNT);
		chk(q[ST_B2A_LSB +: CW], DEPTH_CNT);
		for (int i = 1; i <= DEPTH; i++) begin
			b_rd();
			chk(v, 36'(i));
			a_rd(1'b0);
			chk(v, 36'(i));
		end
		repeat (2) @(posedge clk);
		chk(b_ef, 1'b0);
		chk(a_ef, 1'b0);
	endtask
	task automatic t_same();
		a_put(1'b0, 36'h0aa);
		repeat (3) @(posedge clk);
		fork
			i_pa.xfer(1'b1, 1'b0, 36'h0bb);
			i_pb.xfer(1'b0, 1'b0, '0);
		join
		i_pa.idle();
		i_pb.idle();
		@(posedge clk);
		chk(b_o, 36'h0aa);
		repeat (3) @(posedge clk);
		b_rd();
		chk(v, 36'h0bb);
	endtask
	// word and byte pieces in both lane orders, both directions
	task automatic t_size();
		logic [WIDTH-1:0] m, p, d;
		int w, ln, sh;
		d = 36'h9a5c31e7b;
		for (int c = 0; c < 4; c++) begin
			w = c[1] ? 9 : 18;
			m = (36'h1 << w) - 36'h1;
			ln = c[0] ? 0 : 36 - w;
			b_sz <= c[1] ? SIZE_BYTE : SIZE_WORD;
			b_be <= c[0];
			@(posedge clk);
			for (int k = 0; k < 36 / w; k++) begin
				sh = c[0] ? w * k : 36 - w * (k + 1);
				p = (d >> sh) & m;
				i_pb.xfer(1'b1, 1'b0, (p << ln) | ~(m << ln));
			end
			i_pb.idle();
			repeat (3) @(posedge clk);
			a_rd(1'b0);
			chk(v, d);
			a_put(1'b0, d);
			repeat (3) @(posedge clk);
			for (int k = 0; k < 36 / w; k++) begin
				sh = c[0] ? w * k : 36 - w * (k + 1);
				b_rd();
				chk(v, ((d >> sh) & m) << ln);
			end
		end
		b_sz <= SIZE_LONG;
	endtask
	task automatic t_swap();
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, REG_CTRL, 32'(s));
			a_put(1'b0, 36'h9a5c31e7b);
			b_put(36'h9a5c31e7b);
			repeat (3) @(posedge clk);
			b_rd();
			chk(v, swp(36'h9a5c31e7b, 2'(s)));
			a_rd(1'b0);
			chk(v, swp(36'h9a5c31e7b, 2'(s)));
		end
		wb(1'b1, REG_CTRL, '0);
	endtask
	task automatic t_mail();
		a_put(1'b1, 36'h111);
		chk(mab, 1'b0);
		a_put(1'b1, 36'h222);
		b_sz <= SIZE_MAIL;
		@(posedge clk);
		b_rd();
		chk(v, 36'h111);
		@(posedge clk);
		chk(mab, 1'b1);
		b_put(36'h333);
		chk(mba, 1'b0);
		b_sz <= SIZE_LONG;
		a_rd(1'b1);
		chk(v, 36'h333);
	endtask
	// bad parity flags but stores untouched; generation rewrites bit 8
	task automatic t_par();
		a_put(1'b0, 36'h0);
		chk(a_pe, 1'b1);
		a_put(1'b0, 36'h7);
		chk(a_pe, 1'b0);
		repeat (3) @(posedge clk);
		b_rd();
		chk(v, 36'h0);
		b_rd();
		chk(v, 36'h7);
		wb(1'b1, REG_CTRL, 32'h10);
		a_put(1'b0, 36'h7);
		repeat (3) @(posedge clk);
		b_rd();
		chk(v, 36'h107);
		// odd parity: port b check, port a generation, mailbox read blanks the check
		wb(1'b1, REG_CTRL, 32'h0c);
		b_put(36'h8040201);
		chk(b_pe, 1'b1);
		b_put(36'h0);
		chk(b_pe, 1'b0);
		repeat (3) @(posedge clk);
		a_rd(1'b0);
		chk(v, 36'h8040201);
		a_rd(1'b0);
		chk(v, 36'h804020100);
		a_rd(1'b1);
		chk(a_pe, 1'b1);
		chk(v, 36'h804000333);
		wb(1'b1, REG_CTRL, '0);
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_empty();
		t_fill();
		t_same();
		t_size();
		t_swap();
		t_mail();
		t_par();
		wrap_up();
	end
	// watchdog, far beyond the eight hundred or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
